// ### rtl/madc_spi_device.sv
/*
 slave end of the metering adc serial port: command decode, register
 reads with burst, 8-bit writes, sync counter load.
 assumes sclk stands high outside frames and cs_n frames every transfer;
 sample inputs are on core_clk.
*/
// Operation
// - mosi driven on fall, captured on rise
// - miso changes on falling sclk edge
// - msb first in both directions
// - sclk between 250 khz and 5.6 mhz; host holds sclk high without limit while its read buffer is full
// - miso released unless sending data
// - cs_n low for whole transfer
// - cs_n rise aborts, no register change
// - command: address, read flag, spare bits
// - first data bit on next falling edge
// - after last bit, cs_n high, released
// - command 0x04 streams all output registers; here the burst stops after register 0x05
// - burst may stop at register boundary
// - burst may start at later register
// - write data follows command without gap
// - sync counter: low byte, then high
// - no acknowledge during writes
// - master reads back after each write; the host never does, and the bench leaves the last write unread
// - status bit 0 high through reset
`timescale 1ns/100ps
module madc_spi_device (
  input  wire logic        core_clk,
  input  wire logic        rst,
  madc_spi_if.device       spi,
  input  wire logic [23:0] current_sample,
  input  wire logic [23:0] voltage1_channel_sample,
  input  wire logic [23:0] voltage2_channel_sample,
  input  wire logic [15:0] adc_crc,
  input  wire logic [7:0]  status_in,
  input  wire logic        reset_busy,
  input  wire logic [15:0] sync_counter_capture,
  output logic             wr_valid,
  input  wire logic        wr_ready,
  output logic [4:0]       wr_addr,
  output logic [7:0]       wr_data,
  output logic [11:0]      sync_start_value,
  output logic             sync_start_load
);
  // ==========================================
  // state types
  typedef struct packed {
    madc_pkg::madc_link_ph_t ph;
    logic [2:0]              bitn;
    logic [7:0]              cmd;
    logic [7:0]              wdat;
    logic                    rd_go;
  } madc_link_t;

  typedef struct packed {
    logic       tgl;
    logic [4:0] addr;
    logic [7:0] data;
  } madc_wr_t;

  typedef struct packed {
    logic        started;
    logic        active;
    logic [31:0] sh;
    logic [5:0]  cnt;
    logic [4:0]  addr;
  } madc_tx_t;

  typedef struct packed {
    logic                     cs_s1;
    logic                     cs_s2;
    logic                     tg_s1;
    logic                     tg_s2;
    logic                     tg_seen;
    madc_pkg::madc_out_regs_t regs;
    logic                     pend;
    logic [4:0]               p_addr;
    logic [7:0]               p_data;
    logic                     lo_ok;
    logic [11:0]              sync_val;
    logic                     sync_load;
  } madc_core_t;

  madc_link_t l_q;
  madc_link_t l_d;
  madc_wr_t   w_q;
  madc_wr_t   w_d;
  madc_tx_t   t_q;
  madc_tx_t   t_d;
  madc_core_t c_q;
  madc_core_t c_d;
  logic       link_rst;
  logic       commit;
  logic [4:0] rd_addr;
  logic [4:0] tx_next_addr;

  // ==========================================
  // link side, sclk rising edge
  // frame end clears link state
  assign link_rst     = rst | spi.cs_n;
  assign rd_addr      = l_q.cmd[madc_pkg::CMD_ADDR_MSB:madc_pkg::CMD_ADDR_LSB];
  assign commit       = (l_q.ph == madc_pkg::PH_WRITE) && (l_q.bitn == madc_pkg::BIT_LAST);
  assign tx_next_addr = t_q.addr + 5'h01;

  always_comb begin
    l_d = l_q;
    case (l_q.ph)
      madc_pkg::PH_CMD: begin
        l_d.cmd  = {l_q.cmd[6:0], spi.mosi};
        l_d.bitn = l_q.bitn + 3'h1;
        if (l_q.bitn == madc_pkg::BIT_LAST) begin
          if (l_d.cmd[madc_pkg::CMD_RD_BIT]) begin
            l_d.ph    = madc_pkg::PH_READ;
            l_d.rd_go = 1'b1;
          end else begin
            l_d.ph = madc_pkg::PH_WRITE;
          end
        end
      end
      madc_pkg::PH_WRITE: begin
        l_d.wdat = {l_q.wdat[6:0], spi.mosi};
        l_d.bitn = l_q.bitn + 3'h1;
        if (l_q.bitn == madc_pkg::BIT_LAST) begin
          l_d.ph = madc_pkg::PH_DONE;
        end
      end
      // read data time and trailing clocks: mosi ignored
      default: l_d = l_q;
    endcase
  end

  always_ff @(posedge spi.sclk or posedge link_rst) begin
    if (link_rst) begin
      l_q <= '0;
    end else begin
      l_q <= l_d;
    end
  end

  // write hand-off, toggle must survive frame end
  always_comb begin
    w_d = w_q;
    // only a full 16-bit frame commits
    if (commit) begin
      w_d.tgl  = ~w_q.tgl;
      w_d.addr = rd_addr;
      w_d.data = {l_q.wdat[6:0], spi.mosi};
    end
  end

  always_ff @(posedge spi.sclk or posedge rst) begin
    if (rst) begin
      w_q <= '0;
    end else begin
      w_q <= w_d;
    end
  end

  // ==========================================
  // link side, sclk falling edge
  always_comb begin
    t_d = t_q;
    if (!t_q.started && l_q.rd_go) begin
      // first data bit on next fall
      t_d.started = 1'b1;
      t_d.active  = 1'b1;
      t_d.addr    = rd_addr;
      t_d.sh      = madc_pkg::madc_reg_word(c_q.regs, rd_addr);
      t_d.cnt     = madc_pkg::madc_reg_len(rd_addr);
    end else if (t_q.active) begin
      if (t_q.cnt == 6'h01) begin
        // chain runs on from start address
        if (t_q.addr < madc_pkg::ADDR_SNAP) begin
          t_d.addr = tx_next_addr;
          t_d.sh   = madc_pkg::madc_reg_word(c_q.regs, tx_next_addr);
          t_d.cnt  = madc_pkg::madc_reg_len(tx_next_addr);
        end else begin
          t_d.active = 1'b0;
        end
      end else begin
        t_d.sh  = {t_q.sh[30:0], 1'b0};
        t_d.cnt = t_q.cnt - 6'h01;
      end
    end
  end

  // cs_n high stops the stream at once
  always_ff @(negedge spi.sclk or posedge link_rst) begin
    if (link_rst) begin
      t_q <= '0;
    end else begin
      t_q <= t_d;
    end
  end

  assign spi.miso_o    = t_q.sh[31];
  assign spi.miso_oe_n = ~t_q.active;

  // ==========================================
  // core side
  // shadow only refreshes while cs_n is high, so the sclk side reads a frozen copy;
  // hazard: a frame opened less than three core cycles before the falling edge after its eighth rise
  always_comb begin
    c_d           = c_q;
    c_d.cs_s1     = spi.cs_n;
    c_d.cs_s2     = c_q.cs_s1;
    c_d.tg_s1     = w_q.tgl;
    c_d.tg_s2     = c_q.tg_s1;
    c_d.sync_load = 1'b0;
    if (c_q.cs_s2) begin
      c_d.regs.current = current_sample;
      c_d.regs.v1      = voltage1_channel_sample;
      c_d.regs.v2      = voltage2_channel_sample;
      c_d.regs.crc     = adc_crc;
      c_d.regs.snap    = sync_counter_capture;
      c_d.regs.status  = status_in;
      c_d.regs.status[madc_pkg::STATUS_RESET_ON_BIT] = reset_busy;
    end
    if (c_q.pend && wr_ready) begin
      c_d.pend = 1'b0;
    end
    // new word arriving while one is held overwrites it
    if (c_q.tg_s2 != c_q.tg_seen) begin
      c_d.tg_seen = c_q.tg_s2;
      c_d.pend    = 1'b1;
      c_d.p_addr  = w_q.addr;
      c_d.p_data  = w_q.data;
      // low byte arms, high byte loads
      if (w_q.addr == madc_pkg::ADDR_CNT_LO) begin
        c_d.regs.cnt_lo = w_q.data;
        c_d.lo_ok       = 1'b1;
      end
      if (w_q.addr == madc_pkg::ADDR_CNT_HI) begin
        c_d.regs.cnt_hi = w_q.data;
        if (c_q.lo_ok) begin
          c_d.sync_val  = {w_q.data[3:0], c_q.regs.cnt_lo};
          c_d.sync_load = 1'b1;
          c_d.lo_ok     = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      c_q             <= '0;
      c_q.cs_s1       <= 1'b1;
      c_q.cs_s2       <= 1'b1;
      c_q.regs.status <= madc_pkg::STATUS_RST;
    end else begin
      c_q <= c_d;
    end
  end

  assign wr_valid         = c_q.pend;
  assign wr_addr          = c_q.p_addr;
  assign wr_data          = c_q.p_data;
  assign sync_start_value = c_q.sync_val;
  assign sync_start_load  = c_q.sync_load;
endmodule // madc_spi_device

// ### rtl/madc_pkg.sv
/*
 package for the metering adc spi slave and its master:
 command layout, register map, link timing, state encodings.
 assumes a 40 mhz core clock on both ends.
*/
package madc_pkg;
  // ==========================================
  // timing
  localparam int unsigned CORE_CLK_KHZ  = 40000;
  localparam int unsigned SCLK_MAX_KHZ  = 5600;
  localparam int unsigned SCLK_MIN_KHZ  = 250;
  localparam int unsigned SCLK_HALF_CYC = (CORE_CLK_KHZ + 2 * SCLK_MAX_KHZ - 1) / (2 * SCLK_MAX_KHZ);
  localparam logic [2:0]  SCLK_HALF_LAST = 3'(SCLK_HALF_CYC - 1);

  // ==========================================
  // command byte
  localparam int unsigned CMD_ADDR_MSB = 7;
  localparam int unsigned CMD_ADDR_LSB = 3;
  localparam int unsigned CMD_RD_BIT   = 2;
  localparam logic [2:0]  BIT_LAST     = 3'h7;

  // ==========================================
  // register map
  localparam logic [4:0] ADDR_CURRENT = 5'h00;
  localparam logic [4:0] ADDR_V1      = 5'h01;
  localparam logic [4:0] ADDR_V2      = 5'h02;
  localparam logic [4:0] ADDR_CRC     = 5'h03;
  localparam logic [4:0] ADDR_STATUS  = 5'h04;
  localparam logic [4:0] ADDR_SNAP    = 5'h05;
  localparam logic [4:0] ADDR_CNT_LO  = 5'h06;
  localparam logic [4:0] ADDR_CNT_HI  = 5'h07;
  localparam logic [5:0] LEN_SAMPLE   = 6'h18;
  localparam logic [5:0] LEN_WORD16   = 6'h10;
  localparam logic [5:0] LEN_BYTE     = 6'h08;
  localparam logic [7:0] STATUS_RST   = 8'h01;
  localparam int unsigned STATUS_RESET_ON_BIT = 0;

  typedef struct packed {
    logic [23:0] current;
    logic [23:0] v1;
    logic [23:0] v2;
    logic [15:0] crc;
    logic [7:0]  status;
    logic [15:0] snap;
    logic [7:0]  cnt_lo;
    logic [7:0]  cnt_hi;
  } madc_out_regs_t;

  typedef enum logic [1:0] {
    PH_CMD   = 2'b00,
    PH_READ  = 2'b01,
    PH_WRITE = 2'b10,
    PH_DONE  = 2'b11
  } madc_link_ph_t;

  typedef enum logic [2:0] {
    H_IDLE  = 3'b000,
    H_SETUP = 3'b001,
    H_LOW   = 3'b010,
    H_HIGH  = 3'b011,
    H_LAST  = 3'b100,
    H_GAP   = 3'b101
  } madc_host_st_t;

  function automatic logic [5:0] madc_reg_len(input logic [4:0] a);
    case (a)
      ADDR_CURRENT, ADDR_V1, ADDR_V2: madc_reg_len = LEN_SAMPLE;
      ADDR_CRC, ADDR_SNAP:            madc_reg_len = LEN_WORD16;
      default:                        madc_reg_len = LEN_BYTE;
    endcase
  endfunction

  // word left aligned so bit 31 is always the next bit out
  function automatic logic [31:0] madc_reg_word(input madc_out_regs_t r, input logic [4:0] a);
    case (a)
      ADDR_CURRENT: madc_reg_word = {r.current, 8'h00};
      ADDR_V1:      madc_reg_word = {r.v1, 8'h00};
      ADDR_V2:      madc_reg_word = {r.v2, 8'h00};
      ADDR_CRC:     madc_reg_word = {r.crc, 16'h0000};
      ADDR_STATUS:  madc_reg_word = {r.status, 24'h000000};
      ADDR_SNAP:    madc_reg_word = {r.snap, 16'h0000};
      ADDR_CNT_LO:  madc_reg_word = {r.cnt_lo, 24'h000000};
      ADDR_CNT_HI:  madc_reg_word = {r.cnt_hi, 24'h000000};
      default:      madc_reg_word = 32'h00000000;
    endcase
  endfunction
endpackage

// ### rtl/madc_spi_if.sv
/*
 four-wire serial link between the master and one slave.
 assumes pull-ups on both data lines: a released line reads high.
*/
`timescale 1ns/100ps
interface madc_spi_if;
  logic sclk;
  logic cs_n;
  logic mosi_o;
  logic mosi_oe_n;
  logic mosi;
  logic miso_o;
  logic miso_oe_n;
  logic miso;

  // ==========================================
  // wire resolution, pull-up when released
  assign mosi = mosi_oe_n ? 1'b1 : mosi_o;
  assign miso = miso_oe_n ? 1'b1 : miso_o;

  modport device (input sclk, input cs_n, input mosi, output miso_o, output miso_oe_n);
  modport host (output sclk, output cs_n, output mosi_o, output mosi_oe_n, input miso);
endinterface

// ### rtl/madc_spi_host.sv
/*
 master end of the metering adc serial port: one command at a time,
 sclk divided from core_clk, read bytes through a two-entry buffer.
 assumes miso is pulled high when released.
*/
`timescale 1ns/100ps
module madc_spi_host (
  input  wire logic       core_clk,
  input  wire logic       rst,
  madc_spi_if.host        spi,
  input  wire logic       cmd_valid,
  output logic            cmd_ready,
  input  wire logic       cmd_read,
  input  wire logic [4:0] cmd_addr,
  input  wire logic [7:0] cmd_wdata,
  input  wire logic [3:0] cmd_nbytes,
  output logic            rd_valid,
  input  wire logic       rd_ready,
  output logic [7:0]      rd_data,
  output logic            busy
);
  // ==========================================
  // state
  typedef struct packed {
    madc_pkg::madc_host_st_t st;
    logic [2:0]              half;
    logic                    sclk;
    logic                    cs_n;
    logic                    mosi;
    logic                    oe_n;
    logic                    rd;
    logic                    in_cmd;
    logic [2:0]              bitn;
    logic [3:0]              left;
    logic [7:0]              tx;
    logic [7:0]              wbyte;
    logic [7:0]              rx;
    logic                    ms1;
    logic                    ms2;
    logic [1:0][7:0]         mem;
    logic                    wp;
    logic                    rp;
    logic [1:0]              cnt;
  } madc_host_t;

  madc_host_t h_q;
  madc_host_t h_d;
  logic       tick;
  logic       pop;
  logic       push;

  assign tick = (h_q.half == madc_pkg::SCLK_HALF_LAST);
  assign pop  = (h_q.cnt != 2'h0) && rd_ready;

  always_comb begin
    h_d     = h_q;
    push    = 1'b0;
    h_d.ms1 = spi.miso;
    h_d.ms2 = h_q.ms1;
    if (h_q.st != madc_pkg::H_IDLE) begin
      h_d.half = tick ? 3'h0 : h_q.half + 3'h1;
    end
    case (h_q.st)
      madc_pkg::H_IDLE: begin
        if (cmd_valid) begin
          h_d.tx     = {cmd_addr, cmd_read, 2'b00};
          h_d.wbyte  = cmd_wdata;
          h_d.rd     = cmd_read;
          h_d.left   = (cmd_read && cmd_nbytes != 4'h0) ? cmd_nbytes : 4'h1;
          h_d.in_cmd = 1'b1;
          h_d.bitn   = 3'h0;
          // cs_n held low to the end
          h_d.cs_n   = 1'b0;
          h_d.oe_n   = 1'b0;
          h_d.st     = madc_pkg::H_SETUP;
        end
      end
      madc_pkg::H_SETUP, madc_pkg::H_HIGH: begin
        if (tick) begin
          // stall between read bytes while the buffer is full
          if (h_q.st == madc_pkg::H_HIGH && h_q.rd && !h_q.in_cmd && h_q.bitn == 3'h0 && h_q.cnt == 2'h2) begin
            h_d.half = h_q.half;
          end else begin
            h_d.sclk = 1'b0;
            h_d.mosi = h_q.tx[7];
            h_d.tx   = {h_q.tx[6:0], 1'b0};
            h_d.st   = madc_pkg::H_LOW;
          end
        end
      end
      madc_pkg::H_LOW: begin
        if (tick) begin
          h_d.sclk = 1'b1;
          h_d.rx   = {h_q.rx[6:0], h_q.ms2};
          h_d.bitn = h_q.bitn + 3'h1;
          h_d.st   = madc_pkg::H_HIGH;
          if (h_q.bitn == madc_pkg::BIT_LAST) begin
            if (h_q.in_cmd) begin
              // data byte follows with no gap
              h_d.in_cmd = 1'b0;
              h_d.tx     = h_q.wbyte;
            end else begin
              push     = h_q.rd;
              h_d.left = h_q.left - 4'h1;
              if (h_q.left == 4'h1) begin
                h_d.st = madc_pkg::H_LAST;
              end
            end
          end
        end
      end
      madc_pkg::H_LAST: begin
        if (tick) begin
          h_d.cs_n = 1'b1;
          h_d.oe_n = 1'b1;
          h_d.st   = madc_pkg::H_GAP;
        end
      end
      madc_pkg::H_GAP: begin
        if (tick) begin
          h_d.st = madc_pkg::H_IDLE;
        end
      end
      default: h_d.st = madc_pkg::H_IDLE;
    endcase
    if (push) begin
      h_d.mem[h_q.wp] = {h_q.rx[6:0], h_q.ms2};
      h_d.wp          = ~h_q.wp;
    end
    if (pop) begin
      h_d.rp = ~h_q.rp;
    end
    h_d.cnt = h_q.cnt + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      h_q      <= '0;
      h_q.sclk <= 1'b1;
      h_q.cs_n <= 1'b1;
      h_q.oe_n <= 1'b1;
    end else begin
      h_q <= h_d;
    end
  end

  assign spi.sclk      = h_q.sclk;
  assign spi.cs_n      = h_q.cs_n;
  assign spi.mosi_o    = h_q.mosi;
  assign spi.mosi_oe_n = h_q.oe_n;
  assign cmd_ready     = (h_q.st == madc_pkg::H_IDLE);
  assign busy          = (h_q.st != madc_pkg::H_IDLE);
  assign rd_valid      = (h_q.cnt != 2'h0);
  assign rd_data       = h_q.mem[h_q.rp];
endmodule // madc_spi_host

// ### testbench/madc_spi_assertions.sv
/*
 concurrent checks on the serial link between host end and device end.
 assumes the bench instantiates it beside the link interface, on core_clk.
*/
`timescale 1ns/100ps
module madc_spi_assertions (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi_o,
  input wire logic mosi_oe_n,
  input wire logic mosi,
  input wire logic miso_o,
  input wire logic miso_oe_n
);
  // ==========================================
  // helper: rises per frame and command byte
  logic       sclk_q;
  logic [7:0] rises_q;
  logic [7:0] cmd_q;
  logic       rise;

  // sclk is sampled on core_clk, it is slow enough to see every edge
  assign rise = sclk && !sclk_q;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sclk_q  <= 1'b1;
      rises_q <= 8'h00;
      cmd_q   <= 8'h00;
    end else begin
      sclk_q <= sclk;
      if (cs_n) begin
        rises_q <= 8'h00;
      end else if (rise && rises_q != 8'hff) begin
        rises_q <= rises_q + 8'h01;
        if (rises_q < 8'h08) begin
          cmd_q <= {cmd_q[6:0], mosi};
        end
      end
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  // ==========================================
  // properties
  property p_mosi_on_fall;
    $changed(mosi_o) && !mosi_oe_n && $past(!mosi_oe_n) |-> $fell(sclk);
  endproperty
  property p_miso_on_fall;
    $changed(miso_o) && !miso_oe_n |-> !sclk;
  endproperty
  property p_low_half;
    $fell(sclk) |-> (!sclk)[*4] ##1 sclk;
  endproperty
  property p_high_half;
    $rose(sclk) |-> sclk[*4];
  endproperty
  property p_miso_read_only;
    !miso_oe_n |-> !cs_n && cmd_q[2] && rises_q >= 8'h08;
  endproperty
  property p_write_silent;
    rise && rises_q == 8'h08 && !cmd_q[2] |-> miso_oe_n[*8];
  endproperty
  property p_first_bit;
    $fell(miso_oe_n) |-> !sclk && $past(sclk) && rises_q == 8'h08;
  endproperty
  property p_end_high;
    $rose(cs_n) |-> sclk && mosi_oe_n && miso_oe_n;
  endproperty
  property p_clock_in_frame;
    $changed(sclk) |-> !cs_n && $past(!cs_n);
  endproperty
  property p_idle_released;
    cs_n |-> miso_oe_n && mosi_oe_n;
  endproperty

  a_mosi_on_fall: assert property (p_mosi_on_fall)
    else $error("mosi changed away from a falling sclk");
  a_miso_on_fall: assert property (p_miso_on_fall)
    else $error("miso changed while sclk high");
  a_low_half: assert property (p_low_half)
    else $error("sclk low half not four core cycles");
  a_high_half: assert property (p_high_half)
    else $error("sclk high half shorter than four core cycles");
  a_miso_read_only: assert property (p_miso_read_only)
    else $error("miso driven outside read data");
  a_write_silent: assert property (p_write_silent)
    else $error("miso driven during write data");
  a_first_bit: assert property (p_first_bit)
    else $error("first read bit not on fall after eighth rise");
  a_end_high: assert property (p_end_high)
    else $error("frame ended with sclk low or lines driven");
  a_clock_in_frame: assert property (p_clock_in_frame)
    else $error("sclk moved outside a frame");
  a_idle_released: assert property (p_idle_released)
    else $error("data line driven while deselected");

  c_read: cover property ($fell(miso_oe_n));
  // sixteenth rise of a write frame, the last one it has
  c_write: cover property (rise && rises_q == 8'h0f && !cmd_q[2]);
  c_burst: cover property (!miso_oe_n && rises_q > 8'h60);
endmodule // madc_spi_assertions

// ### testbench/testbench.sv
/*
 testbench: host end and device end joined by the link interface,
 driven through the host command port and the device write port.
 assumes one 40 mhz core clock for both ends; sclk comes from the host.
*/
`timescale 1ns/100ps
module testbench;
  logic        core_clk = 1'b0;
  logic        rst = 1'b0;
  logic        cmd_valid = 1'b0;
  logic        cmd_ready;
  logic        cmd_read = 1'b0;
  logic [4:0]  cmd_addr = 5'h00;
  logic [7:0]  cmd_wdata = 8'h00;
  logic [3:0]  cmd_nbytes = 4'h1;
  logic        rd_valid;
  logic        rd_ready = 1'b0;
  logic [7:0]  rd_data;
  logic        busy;
  logic [23:0] current_sample = 24'h9a3c51;
  logic [23:0] voltage1_channel_sample = 24'h7e0412;
  logic [23:0] voltage2_channel_sample = 24'h13f0c8;
  logic [15:0] adc_crc = 16'hb2d7;
  logic [7:0]  status_in = 8'ha4;
  logic        reset_busy = 1'b1;
  logic [15:0] sync_counter_capture = 16'h06e1;
  logic        wr_valid;
  logic        wr_ready = 1'b0;
  logic [4:0]  wr_addr;
  logic [7:0]  wr_data;
  logic [11:0] sync_start_value;
  logic        sync_start_load;
  logic [7:0]  lo_w = 8'h00;
  logic [7:0]  hi_w = 8'h00;
  int          failures = 0;
  int          checked = 0;
  int          loads = 0;

  always #12.5 core_clk = ~core_clk;

  madc_spi_if spi_if ();
  madc_spi_device madc_spi_device_i (.core_clk, .rst, .spi(spi_if), .current_sample, .voltage1_channel_sample,
    .voltage2_channel_sample, .adc_crc, .status_in, .reset_busy, .sync_counter_capture, .wr_valid, .wr_ready,
    .wr_addr, .wr_data, .sync_start_value, .sync_start_load);
  madc_spi_host madc_spi_host_i (.core_clk, .rst, .spi(spi_if), .cmd_valid, .cmd_ready, .cmd_read, .cmd_addr,
    .cmd_wdata, .cmd_nbytes, .rd_valid, .rd_ready, .rd_data, .busy);
  madc_spi_assertions madc_spi_assertions_i (.core_clk, .rst, .sclk(spi_if.sclk), .cs_n(spi_if.cs_n),
    .mosi_o(spi_if.mosi_o), .mosi_oe_n(spi_if.mosi_oe_n), .mosi(spi_if.mosi), .miso_o(spi_if.miso_o),
    .miso_oe_n(spi_if.miso_oe_n));

  always @(posedge core_clk) begin
    if (sync_start_load === 1'b1) begin
      loads++;
    end
  end

  // ==========================================
  // expected register contents, left aligned
  function automatic logic [31:0] word_of(input logic [4:0] a);
    case (a)
      5'h00: word_of = {current_sample, 8'h00};
      5'h01: word_of = {voltage1_channel_sample, 8'h00};
      5'h02: word_of = {voltage2_channel_sample, 8'h00};
      5'h03: word_of = {adc_crc, 16'h0000};
      5'h04: word_of = {status_in[7:1], reset_busy, 24'h000000};
      5'h05: word_of = {sync_counter_capture, 16'h0000};
      5'h06: word_of = {lo_w, 24'h000000};
      5'h07: word_of = {hi_w, 24'h000000};
      default: word_of = 32'h00000000;
    endcase
  endfunction

  function automatic int len_of(input logic [4:0] a);
    len_of = (a < 5'h03) ? 3 : ((a == 5'h03 || a == 5'h05) ? 2 : 1);
  endfunction

  // ==========================================
  // access tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tick();
    @(posedge core_clk);
    #2;
  endtask

  task automatic give_up();
    failures++;
    report_and_stop();
  endtask

  task automatic idle();
    int i;
    for (i = 0; i < 400 && busy !== 1'b0; i++) tick();
    if (i == 400) give_up();
  endtask

  // request held until the edge that sees cmd_ready high
  task automatic send(input logic r, input logic [4:0] a, input logic [7:0] d, input logic [3:0] n);
    int i;
    cmd_read = r;
    cmd_addr = a;
    cmd_wdata = d;
    cmd_nbytes = n;
    cmd_valid = 1'b1;
    for (i = 0; i < 400 && cmd_ready !== 1'b1; i++) tick();
    if (i == 400) give_up();
    tick();
    cmd_valid = 1'b0;
  endtask

  // rd_ready stays up between bytes so no strobe toggles twice per step
  task automatic get(input logic [7:0] exp);
    int i;
    for (i = 0; i < 400 && rd_valid !== 1'b1; i++) tick();
    if (i == 400) give_up();
    check(rd_data, exp);
    rd_ready = 1'b1;
    tick();
  endtask

  task automatic rd(input logic [4:0] a, input int n, input int stall);
    logic [31:0] w;
    logic [4:0]  x;
    int          j;
    int          k;
    x = a;
    j = 0;
    send(1'b1, a, 8'h00, 4'(n));
    repeat (stall) tick();
    if (stall > 0) begin
      check(busy, 1'b1);
      check(spi_if.sclk, 1'b1);
    end
    for (k = 0; k < n; k++) begin
      w = word_of(x);
      get(w[31 - 8 * j -: 8]);
      j++;
      if (j == len_of(x)) begin
        j = 0;
        x++;
      end
    end
    rd_ready = 1'b0;
    idle();
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    int i;
    send(1'b0, a, d, 4'h1);
    for (i = 0; i < 400 && wr_valid !== 1'b1; i++) tick();
    if (i == 400) give_up();
    check(wr_addr, a);
    check(wr_data, d);
    if (a == 5'h06) lo_w = d;
    if (a == 5'h07) hi_w = d;
    wr_ready = 1'b1;
    tick();
    wr_ready = 1'b0;
    check(wr_valid, 1'b0);
    idle();
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ==========================================
  // scenarios
  initial begin
    // raised after time zero so every async reset branch sees an edge
    #1;
    rst = 1'b1;
    repeat (6) @(posedge core_clk);
    #2;
    rst = 1'b0;
    repeat (5) tick();
    rd(5'h04, 1, 0);
    reset_busy = 1'b0;
    repeat (4) tick();
    rd(5'h04, 1, 0);
    // full burst with the reader stalled until the buffer refuses
    rd(5'h00, 14, 300);
    rd(5'h01, 6, 0);
    rd(5'h03, 2, 0);
    wr(5'h06, 8'h5a);
    check(loads, 0);
    wr(5'h07, 8'h93);
    check(loads, 1);
    check(sync_start_value, 12'h35a);
    rd(5'h06, 1, 0);
    rd(5'h07, 1, 0);
    // high byte alone must not reload the counter
    wr(5'h07, 8'h1c);
    check(loads, 1);
    rd(5'h1f, 1, 0);
    report_and_stop();
  end
endmodule // testbench
